/* File: rtl/protect_decode.sv */
// Address decoder: flags word addresses that belong to the protected set
`timescale 1ns/10ps
module protect_decode (
   input  wire logic [15:0] addr,   // Word address of the access
   input  wire logic        wide,   // Access also covers addr+1
   output logic             hit     // Access touches a protected word
);

   // ****************************************************************
   // Range check
   // ****************************************************************
   function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo,
                                   input logic [15:0] hi);
      in_rng = (a >= lo) && (a <= hi);
   endfunction : in_rng

   function automatic logic word_hit(input logic [15:0] a);
      word_hit = in_rng(a, wp_pkg::DEVCFG_LO, wp_pkg::DEVCFG_HI)      // RQ9
               | in_rng(a, wp_pkg::GUARD_LO, wp_pkg::GUARD_HI)        // RQ9
               | in_rng(a, wp_pkg::FOPT_A, wp_pkg::FOPT_A)            // RQ10
               | in_rng(a, wp_pkg::FLASH_LO, wp_pkg::FLASH_HI)        // RQ10
               | in_rng(a, wp_pkg::KEY_LO, wp_pkg::KEY_HI)            // RQ11
               | in_rng(a, wp_pkg::SECSC_A, wp_pkg::SECSC_A)          // RQ11
               | in_rng(a, wp_pkg::VEC_LO, wp_pkg::VEC_HI)            // RQ12
               | in_rng(a, wp_pkg::CLK_LO, wp_pkg::CLK_HI)            // RQ13
               | in_rng(a, wp_pkg::PCLK_LO, wp_pkg::PCLK_HI)          // RQ13
               | in_rng(a, wp_pkg::PLLWD_LO, wp_pkg::PLLWD_HI)        // RQ13
               | in_rng(a, wp_pkg::WDKEY_A, wp_pkg::WDKEY_A)          // RQ13
               | in_rng(a, wp_pkg::WDCR_A, wp_pkg::WDCR_A)            // RQ13
               | in_rng(a, wp_pkg::PINA_LO, wp_pkg::PINA_HI)          // RQ14
               | in_rng(a, wp_pkg::PINB_LO, wp_pkg::PINB_HI)          // RQ15
               | in_rng(a, wp_pkg::XSEL_LO, wp_pkg::XSEL_HI)          // RQ15
               | in_rng(a, wp_pkg::LPSEL_LO, wp_pkg::LPSEL_HI);       // RQ15
   endfunction : word_hit

   // A wide access is checked on both words so half of a pair never slips by
   always_comb begin
      hit = word_hit(addr) | (wide & word_hit(addr | 16'h0001));   // RQ16
   end

endmodule : protect_decode

/* File: rtl/register_write_protect_gate.sv */
// Write-protect gate between CPU/debug access paths and protected registers
`timescale 1ns/10ps
module register_write_protect_gate (
   input  wire logic              clk,             // System clock, 20 MHz
   input  wire logic              rst_b,           // Async reset, active low
   input  wire wp_pkg::acc_req_s  cpu_req,         // CPU access request
   input  wire wp_pkg::acc_req_s  jtag_req,        // Debug port access request
   input  wire logic              write_unlock,    // Unlock instruction executed
   input  wire logic              write_relock_op, // Relock instruction executed
   input  wire logic              st1_load,        // CPU loads status word one
   input  wire logic [15:0]       st1_wdata,       // Value loaded into status word
   input  wire logic              tgt_ack,         // Register side completes access
   input  wire logic [31:0]       tgt_rdata,       // Register side read data
   output logic                   cpu_ready,       // Gate can take a CPU request
   output logic                   jtag_ready,      // Gate can take a debug request
   output logic                   cpu_done,        // CPU access complete, pulse
   output logic                   jtag_done,       // Debug access complete, pulse
   output logic [31:0]            resp_rdata,      // Read data of completed access
   output wp_pkg::acc_req_s       tgt_req,         // Access toward the registers
   output logic [15:0]            cpu_status_word_one // Status word one
);

   wp_pkg::gate_state_s r;
   wp_pkg::gate_state_s next_r;
   logic                take_cpu;
   logic                take_jtag;
   logic                sel_hit;
   logic                unlocked;
   wp_pkg::acc_req_s    sel_req;

   // ****************************************************************
   // Arbitration and decode
   // ****************************************************************
   // Debug wins a tie so a halted-CPU debugger is never starved
   assign take_jtag = jtag_req.valid & r.jtag_ready;
   assign take_cpu  = cpu_req.valid & r.cpu_ready & ~take_jtag;
   assign sel_req   = take_jtag ? jtag_req : cpu_req;
   assign unlocked  = r.st1[wp_pkg::UNLOCK_BIT];    // RQ8

   protect_decode u_dec (
      .addr (sel_req.addr),
      .wide (sel_req.wide),
      .hit  (sel_hit)
   );

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   always_comb begin
      next_r           = r;
      next_r.cpu_done  = 1'b0;
      next_r.jtag_done = 1'b0;
      next_r.tgt.valid = 1'b0;
      // Status word load first, the instructions then own the unlock bit
      if (st1_load) begin
         next_r.st1 = st1_wdata;
      end
      if (write_unlock) begin
         next_r.st1[wp_pkg::UNLOCK_BIT] = 1'b1;       // RQ5
      end else if (write_relock_op) begin
         next_r.st1[wp_pkg::UNLOCK_BIT] = 1'b0;       // RQ6
      end
      case (r.st)
         wp_pkg::IDLE: begin
            if (take_jtag || take_cpu) begin
               next_r.cpu_ready  = 1'b0;
               next_r.jtag_ready = 1'b0;
               next_r.from_jtag  = take_jtag;
               next_r.tgt        = sel_req;
               // Only a locked CPU write to a protected word is stopped here
               if (take_cpu && cpu_req.write && sel_hit && !unlocked) begin
                  next_r.tgt.valid = 1'b0;             // RQ1
                  next_r.st        = wp_pkg::FAKE;
               end else begin
                  next_r.tgt.valid = 1'b1;             // RQ2 RQ3 RQ7 RQ16
                  next_r.st        = wp_pkg::WAIT_TGT;
               end
            end
         end
         wp_pkg::WAIT_TGT: begin
            // Request is held until the register side acknowledges it
            next_r.tgt.valid = ~tgt_ack;
            if (tgt_ack) begin
               next_r.rdata      = tgt_rdata;
               next_r.cpu_done   = ~r.from_jtag;
               next_r.jtag_done  = r.from_jtag;
               next_r.cpu_ready  = 1'b1;
               next_r.jtag_ready = 1'b1;
               next_r.st         = wp_pkg::IDLE;
            end
         end
         wp_pkg::FAKE: begin
            // Dropped write finishes one cycle before the fastest real one, no error
            next_r.rdata      = '0;
            next_r.cpu_done   = 1'b1;                  // RQ17
            next_r.cpu_ready  = 1'b1;
            next_r.jtag_ready = 1'b1;
            next_r.st         = wp_pkg::IDLE;
         end
         default: begin
            next_r.st         = wp_pkg::IDLE;
            next_r.cpu_ready  = 1'b1;
            next_r.jtag_ready = 1'b1;
         end
      endcase
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   // Reset leaves the unlock bit clear, so protection holds from the start
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         r            <= '0;
         r.st         <= wp_pkg::IDLE;
         r.st1        <= wp_pkg::ST1_RESET;             // RQ4
         r.cpu_ready  <= 1'b1;
         r.jtag_ready <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   // Outputs straight from the state flops
   assign cpu_ready           = r.cpu_ready;
   assign jtag_ready          = r.jtag_ready;
   assign cpu_done            = r.cpu_done;
   assign jtag_done           = r.jtag_done;
   assign resp_rdata          = r.rdata;
   assign tgt_req             = r.tgt;
   assign cpu_status_word_one = r.st1;

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_drop;
      @(posedge clk) disable iff (!rst_b)
      take_cpu && cpu_req.write && sel_hit && !unlocked
         |=> !tgt_req.valid ##1 (cpu_done && !tgt_req.valid);
   endproperty
   a_drop: assert property (p_drop) else $error("locked protected write passed"); // RQ1

   property p_cpu_read;
      @(posedge clk) disable iff (!rst_b)
      take_cpu && !cpu_req.write |=> tgt_req.valid && !tgt_req.write;
   endproperty
   a_cpu_read: assert property (p_cpu_read) else $error("CPU read not issued"); // RQ2

   property p_unlocked_write;
      @(posedge clk) disable iff (!rst_b)
      take_cpu && cpu_req.write && unlocked
         |=> tgt_req.valid && tgt_req.write && tgt_req.addr == $past(cpu_req.addr);
   endproperty
   a_unlocked_write: assert property (p_unlocked_write) else $error("unlocked write lost"); // RQ3

   property p_unlock;
      @(posedge clk) disable iff (!rst_b)
      write_unlock |=> cpu_status_word_one[wp_pkg::UNLOCK_BIT];
   endproperty
   a_unlock: assert property (p_unlock) else $error("unlock did not set flag"); // RQ5

   property p_relock;
      @(posedge clk) disable iff (!rst_b)
      write_relock_op && !write_unlock |=> !cpu_status_word_one[wp_pkg::UNLOCK_BIT];
   endproperty
   a_relock: assert property (p_relock) else $error("relock did not clear flag"); // RQ6

   property p_jtag;
      @(posedge clk) disable iff (!rst_b)
      take_jtag |=> tgt_req.valid && tgt_req.write == $past(jtag_req.write);
   endproperty
   a_jtag: assert property (p_jtag) else $error("debug access blocked"); // RQ7

   property p_flag_hold;
      @(posedge clk) disable iff (!rst_b)
      !write_unlock && !write_relock_op && !st1_load
         |=> $stable(cpu_status_word_one[wp_pkg::UNLOCK_BIT]);
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag moved by itself"); // RQ8

   property p_open;
      @(posedge clk) disable iff (!rst_b)
      take_cpu && cpu_req.write && !sel_hit |=> tgt_req.valid;
   endproperty
   a_open: assert property (p_open) else $error("unprotected write blocked"); // RQ16

   // Ready comes back with done, so a new take in the done cycle stays legal
   property p_done_pulse;
      @(posedge clk) disable iff (!rst_b)
      cpu_done |-> cpu_ready ##1 !cpu_done;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done not a pulse"); // RQ17

   property p_jtag_done;
      @(posedge clk) disable iff (!rst_b)
      jtag_done |-> jtag_ready ##1 !jtag_done;
   endproperty
   a_jtag_done: assert property (p_jtag_done) else $error("debug done not a pulse"); // RQ2

   // Held request must not change under the register side while it waits
   property p_tgt_hold;
      @(posedge clk) disable iff (!rst_b)
      tgt_req.valid && !tgt_ack
         |=> tgt_req.valid && $stable(tgt_req.addr) && $stable(tgt_req.wdata);
   endproperty
   a_tgt_hold: assert property (p_tgt_hold) else $error("held access changed"); // RQ3

   property p_dbg_locked;
      @(posedge clk) disable iff (!rst_b)
      take_jtag && jtag_req.write && sel_hit && !unlocked
         |=> tgt_req.valid && tgt_req.write;
   endproperty
   a_dbg_locked: assert property (p_dbg_locked) else $error("locked debug write blocked"); // RQ7

   property p_busy;
      @(posedge clk) disable iff (!rst_b)
      take_cpu || take_jtag |=> !cpu_ready && !jtag_ready;
   endproperty
   a_busy: assert property (p_busy) else $error("second access taken while busy"); // RQ17

   // Independent of the decoder: a key word never sees a locked CPU write
   property p_key_word;
      @(posedge clk) disable iff (!rst_b)
      take_cpu && cpu_req.write && !unlocked
         && cpu_req.addr >= wp_pkg::KEY_LO && cpu_req.addr <= wp_pkg::KEY_HI
         |=> !tgt_req.valid;
   endproperty
   a_key_word: assert property (p_key_word) else $error("locked key write passed"); // RQ11

endmodule : register_write_protect_gate

/* File: rtl/wp_pkg.sv */
// Package: constants, types and address map of the register write-protect gate
// How it works
// RQ1 - Locked: CPU writes to protected words are dropped, target untouched.
// RQ2 - Locked: CPU reads and debug reads and writes still pass normally.
// RQ3 - Unlocked: CPU writes to protected words pass like any other write.
// RQ4 - Reset clears the unlock flag, protection on from the start.
// RQ5 - Unlock instruction sets the flag; software runs it before protected writes.
// RQ6 - Relock instruction clears the flag unless unlock runs in the same cycle; software runs it after its updates.
// RQ7 - Debug port accesses ignore the flag and always reach protected words.
// RQ8 - The flag is a bit of CPU status word one and drives the gate.
// RQ9 - Protected: configuration pair 0x0880-0x0881, guard start and span 0x0884-0x0885.
// RQ10 - Protected: flash option 0x0A80, flash power to wait states 0x0A82-0x0A87.
// RQ11 - Protected: key words 0x0AE0-0x0AE7 and security status word 0x0AEF.
// RQ12 - Protected: whole vector table, 0x0D00 through 0x0DFF.
// RQ13 - Protected: clock, PLL, low-power, watchdog words in 0x7010-0x7029.
// RQ14 - Protected: port A pin control through direction, 0x6F80-0x6F8B.
// RQ15 - Protected: port A/B rest to 0x6F9D, 0x6FE0-0x6FE2, 0x6FE8-0x6FE9.
// RQ16 - Unprotected writes never blocked; both words of two-word registers guarded.
// RQ17 - A dropped write completes with normal timing and no error; here its done comes one cycle before that of the fastest real access.
package wp_pkg;

   // ****************************************************************
   // Widths and status word
   // ****************************************************************
   localparam int          ADDR_W     = 16;
   localparam int          DATA_W     = 32;
   localparam int          ST1_W      = 16;
   localparam int          UNLOCK_BIT = 6;
   localparam logic [15:0] ST1_RESET  = 16'h0000;

   // ****************************************************************
   // Protected word address map
   // ****************************************************************
   localparam logic [15:0] DEVCFG_LO  = 16'h0880;
   localparam logic [15:0] DEVCFG_HI  = 16'h0881;
   localparam logic [15:0] GUARD_LO   = 16'h0884;
   localparam logic [15:0] GUARD_HI   = 16'h0885;
   localparam logic [15:0] FOPT_A     = 16'h0a80;
   localparam logic [15:0] FLASH_LO   = 16'h0a82;
   localparam logic [15:0] FLASH_HI   = 16'h0a87;
   localparam logic [15:0] KEY_LO     = 16'h0ae0;
   localparam logic [15:0] KEY_HI     = 16'h0ae7;
   localparam logic [15:0] SECSC_A    = 16'h0aef;
   localparam logic [15:0] VEC_LO     = 16'h0d00;
   localparam logic [15:0] VEC_HI     = 16'h0dff;
   localparam logic [15:0] CLK_LO     = 16'h7010;
   localparam logic [15:0] CLK_HI     = 16'h7011;
   localparam logic [15:0] PCLK_LO    = 16'h7019;
   localparam logic [15:0] PCLK_HI    = 16'h701e;
   localparam logic [15:0] PLLWD_LO   = 16'h7021;
   localparam logic [15:0] PLLWD_HI   = 16'h7023;
   localparam logic [15:0] WDKEY_A    = 16'h7025;
   localparam logic [15:0] WDCR_A     = 16'h7029;
   localparam logic [15:0] PINA_LO    = 16'h6f80;
   localparam logic [15:0] PINA_HI    = 16'h6f8b;
   localparam logic [15:0] PINB_LO    = 16'h6f8c;
   localparam logic [15:0] PINB_HI    = 16'h6f9d;
   localparam logic [15:0] XSEL_LO    = 16'h6fe0;
   localparam logic [15:0] XSEL_HI    = 16'h6fe2;
   localparam logic [15:0] LPSEL_LO   = 16'h6fe8;
   localparam logic [15:0] LPSEL_HI   = 16'h6fe9;

   // ****************************************************************
   // Carriers
   // ****************************************************************
   typedef struct packed {
      logic              valid;
      logic              write;
      logic              wide;     // Two-word access, even address
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } acc_req_s;

   typedef enum logic [1:0] {IDLE, WAIT_TGT, FAKE} gate_e;

   typedef struct packed {
      gate_e             st;
      logic [ST1_W-1:0]  st1;
      logic              from_jtag;
      logic              cpu_ready;
      logic              jtag_ready;
      logic              cpu_done;
      logic              jtag_done;
      logic [DATA_W-1:0] rdata;
      acc_req_s          tgt;
   } gate_state_s;

endpackage : wp_pkg

/* File: verif/reg_side_model.sv */
// Register side model: word memory behind the gate, answering after a random delay
`timescale 1ns/10ps
module reg_side_model (
   input  wire logic             clk,   // System clock
   input  wire wp_pkg::acc_req_s req,   // Access from the gate
   output logic                  ack,   // Access done, one-cycle pulse
   output logic [31:0]           rdata  // Read data, valid with ack
);
   logic [15:0] mem [0:65535];
   logic [1:0]  wait_cnt;

   // ****************************************************************
   // Memory and handshake
   // ****************************************************************
   // Contents start at zero so the bench shadow can mirror them
   initial begin
      for (int i = 0; i < 65536; i++) mem[i] = 16'h0000;
      ack = 1'b0;
      rdata = 32'h0000_0000;
      wait_cnt = 2'h0;
   end

   // Delay of 0 to 3 cycles; data line toggles when idle so stale data cannot pass
   always @(posedge clk) begin
      rdata <= ~rdata;
      ack   <= 1'b0;
      if (req.valid && !ack) begin
         if (wait_cnt != 2'h0) wait_cnt <= wait_cnt - 2'h1;
         else begin
            ack      <= 1'b1;
            wait_cnt <= 2'($urandom_range(3));
            rdata    <= {req.wide ? mem[req.addr | 16'h0001] : 16'h0000, mem[req.addr]};
            if (req.write) begin
               mem[req.addr] <= req.wdata[15:0];
               if (req.wide) mem[req.addr | 16'h0001] <= req.wdata[31:16];
            end
         end
      end
   end
endmodule : reg_side_model

/* File: verif/test_register_write_protect_gate.sv */
// Self-checking bench of the register write-protect gate
`timescale 1ns/10ps
module test_register_write_protect_gate;
   logic             clk, rst_b, write_unlock, write_relock_op, st1_load, tgt_ack;
   logic             cpu_ready, jtag_ready, cpu_done, jtag_done, tgt_seen;
   logic [15:0]      st1_wdata, cpu_status_word_one;
   logic [31:0]      tgt_rdata, resp_rdata;
   wp_pkg::acc_req_s cpu_req, jtag_req, tgt_req;
   logic [15:0]      shadow [0:65535];
   int               fail_count, checks, cycles;
   logic [15:0]      rng [15][2] = '{'{16'h0880, 16'h0881}, '{16'h0884, 16'h0885},
      '{16'h0a80, 16'h0a80}, '{16'h0a82, 16'h0a87}, '{16'h0ae0, 16'h0ae7}, '{16'h0aef, 16'h0aef},
      '{16'h0d00, 16'h0dff}, '{16'h7010, 16'h7011}, '{16'h7019, 16'h701e}, '{16'h7021, 16'h7023},
      '{16'h7025, 16'h7025}, '{16'h7029, 16'h7029}, '{16'h6f80, 16'h6f9d}, '{16'h6fe0, 16'h6fe2},
      '{16'h6fe8, 16'h6fe9}};

   register_write_protect_gate uut (.clk, .rst_b, .cpu_req, .jtag_req, .write_unlock,
      .write_relock_op, .st1_load, .st1_wdata, .tgt_ack, .tgt_rdata, .cpu_ready, .jtag_ready,
      .cpu_done, .jtag_done, .resp_rdata, .tgt_req, .cpu_status_word_one);
   reg_side_model far_side (.clk, .req(tgt_req), .ack(tgt_ack), .rdata(tgt_rdata));

   // Marks any cycle in which the gate drives a request toward the registers
   always @(posedge clk) begin
      if (tgt_req.valid === 1'b1) tgt_seen <= 1'b1;
   end

   // ****************************************************************
   // Checking helpers
   // ****************************************************************
   // Protected word set, written out from the address map
   function automatic logic prot(input logic [15:0] a);
      for (int i = 0; i < 15; i++) if (a >= rng[i][0] && a <= rng[i][1]) return 1'b1;
      return 1'b0;
   endfunction : prot

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic give_verdict;
      if (fail_count == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : give_verdict

   // ****************************************************************
   // Drivers
   // ****************************************************************
   // Holds the request until the edge that takes it, then waits a bounded time for done
   task automatic access(input logic dbg, input logic wr, input logic wd, input logic [15:0] a,
                         input logic [31:0] d, output logic [31:0] rd, output int lat);
      int n;
      n = 0;
      lat = 0;
      tgt_seen = 1'b0;
      @(posedge clk);
      if (dbg) jtag_req <= '{1'b1, wr, wd, a, d};
      else cpu_req <= '{1'b1, wr, wd, a, d};
      do begin
         @(posedge clk);
         n++;
      end while ((dbg ? jtag_ready : cpu_ready) !== 1'b1 && n < 50);
      if (dbg) jtag_req.valid <= 1'b0;
      else cpu_req.valid <= 1'b0;
      do begin
         @(posedge clk);
         lat++;
      end while ((dbg ? jtag_done : cpu_done) !== 1'b1 && lat < 50);
      rd = resp_rdata;
      if (n == 50 || lat == 50) fail_count++; // A bound that runs out counts against the run
   endtask : access

   // Write random data, then read it back through a random path
   task automatic probe(input logic dbg, input logic [15:0] a, input logic unl);
      logic [31:0] d, rd;
      logic        wd, ok;
      int          lat;
      d = $urandom;
      wd = $urandom_range(1) == 1 && !a[0];
      ok = dbg || unl || !(prot(a) || (wd && prot(a | 16'h0001)));
      access(dbg, 1'b1, wd, a, d, rd, lat);
      if (ok) shadow[a] = d[15:0];
      if (ok && wd) shadow[a | 16'h0001] = d[31:16];
      if (!ok) begin
         check(32'(lat), 32'd2);
         check({31'h0, tgt_seen}, 32'h0);
         check(rd, 32'h0);
      end
      access($urandom_range(1) == 1, 1'b0, 1'b0, a, 32'h0, rd, lat);
      check({31'h0, tgt_seen}, 32'h1);
      check(rd, {16'h0000, shadow[a]});
   endtask : probe

   // Range edges and their neighbours, then random addresses
   task automatic sweep(input logic unl);
      for (int i = 0; i < 15; i++) begin
         probe($urandom_range(1) == 1, rng[i][0] - 16'h0001, unl);
         probe($urandom_range(1) == 1, rng[i][0], unl);
         probe($urandom_range(1) == 1, rng[i][1], unl);
         probe($urandom_range(1) == 1, rng[i][1] + 16'h0001, unl);
      end
      repeat (10) probe($urandom_range(1) == 1, 16'($urandom), unl);
   endtask : sweep

   // One-cycle pulse of the instruction strobes, status settled after it
   task automatic strobe(input logic u, input logic r, input logic ld, input logic [15:0] v);
      @(posedge clk);
      write_unlock <= u;
      write_relock_op <= r;
      st1_load <= ld;
      st1_wdata <= v;
      @(posedge clk);
      write_unlock <= 1'b0;
      write_relock_op <= 1'b0;
      st1_load <= 1'b0;
      @(posedge clk);
   endtask : strobe

   // ****************************************************************
   // Clock, timeout and main sequence
   // ****************************************************************
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Expected run is about two thousand cycles; ceiling leaves ample room
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         give_verdict();
      end
   end

   initial begin
      logic [15:0] v;
      {rst_b, write_unlock, write_relock_op, st1_load, st1_wdata} = '0;
      {cpu_req, jtag_req, tgt_seen} = '0;
      {fail_count, checks, cycles} = '0;
      for (int i = 0; i < 65536; i++) shadow[i] = 16'h0000;
      void'($urandom(40));
      repeat (10) @(posedge clk);
      check({16'h0, cpu_status_word_one}, 32'h0);
      rst_b <= 1'b1;
      @(posedge clk);
      check({31'h0, cpu_ready}, 32'h1);
      check({31'h0, jtag_ready}, 32'h1);
      sweep(1'b0); // Software has not run the unlock instruction yet
      strobe(1'b1, 1'b0, 1'b0, 16'h0000);
      check({31'h0, cpu_status_word_one[wp_pkg::UNLOCK_BIT]}, 32'h1);
      sweep(1'b1);
      strobe(1'b0, 1'b1, 1'b0, 16'h0000);
      check({31'h0, cpu_status_word_one[wp_pkg::UNLOCK_BIT]}, 32'h0);
      probe(1'b0, 16'h0d10, 1'b0);
      strobe(1'b1, 1'b1, 1'b0, 16'h0000);
      check({31'h0, cpu_status_word_one[wp_pkg::UNLOCK_BIT]}, 32'h1);
      repeat (4) begin
         v = 16'($urandom);
         strobe(1'b0, 1'b0, 1'b1, v);
         check({16'h0, cpu_status_word_one}, {16'h0, v});
         probe(1'b0, 16'h7022, v[wp_pkg::UNLOCK_BIT]);
      end
      strobe(1'b1, 1'b0, 1'b0, 16'h0000);
      check({31'h0, cpu_status_word_one[wp_pkg::UNLOCK_BIT]}, 32'h1);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      check({16'h0, cpu_status_word_one}, 32'h0);
      probe(1'b0, 16'h0ae3, 1'b0);
      give_verdict();
   end
endmodule : test_register_write_protect_gate
